//--- rtl/crypto_bitperm_pkg.sv
// Encodings, lookup table and shared types for the crypto and bit-permutation unit
package crypto_bitperm_pkg;

  // Major opcodes
  localparam logic [6:0] OPC_REG = 7'h33;  // Register-register group
  localparam logic [6:0] OPC_IMM = 7'h13;  // Register-immediate group

  // Function-3 codes
  localparam logic [2:0] F3_KEYSTEP = 3'h0;  // Key round step
  localparam logic [2:0] F3_ZIP     = 3'h1;  // Interleave
  localparam logic [2:0] F3_UNZIP   = 3'h5;  // De-interleave
  localparam logic [2:0] F3_XNOR    = 3'h4;  // Exclusive-NOR
  localparam logic [2:0] F3_LUT8    = 3'h4;  // Byte lookup
  localparam logic [2:0] F3_LUT4    = 3'h2;  // Nibble lookup

  // Function-7 codes; key step carries the byte selector in bits 6:5
  localparam logic [4:0]  F7_KEYSTEP_LOW = 5'h1a;   // Low five bits of key step
  localparam logic [6:0]  F7_XNOR        = 7'h20;   // Exclusive-NOR
  localparam logic [6:0]  F7_LUT         = 7'h14;   // Both lookups
  localparam logic [11:0] IMM_ZIP        = 12'h08f; // Fixed immediate of both interleaves

  // Linear layer rotations and fixed latency
  localparam logic [4:0] ROT_A          = 5'h0d;  // First rotation (13)
  localparam logic [4:0] ROT_B          = 5'h17;  // Second rotation (23)
  localparam int         LATENCY_CYCLES = 1;      // Issue to result, every op

  // Substitution box, entry 0 in the top byte
  localparam logic [2047:0] SBOX = {
    128'hd690e9fecce13db716b614c228fb2c05, 128'h2b679a762abe04c3aa44132649860699,
    128'h9c4250f491ef987a33540b43edcfac62, 128'he4b31ca9c908e89580df94fa758f3fa6,
    128'h4707a7fcf37317ba83593c19e6854fa8, 128'h686b81b27164da8bf8eb0f4b70569d35,
    128'h1e240e5e6358d1a225227c3b01217887, 128'hd40046579fd327524c3602e7a0c4c89e,
    128'heabf8ad240c738b5a3f7f2cef96115a1, 128'he0ae5da49b341a55ad933230f58cb1e3,
    128'h1df6e22e8266ca60c02923ab0d534e6f, 128'hd5db3745defd8e2f03ff6a726d6c5b51,
    128'h8d1baf92bbddbc7f11d95c411f105ad8, 128'h0ac13188a5cd7bbd2d74d012b8e5b4b0,
    128'h8969974a0c96777e65b9f109c56ec684, 128'h18f07dec3adc4d2079ee5f3ed7cb3948};

  // Instruction word split into its fields
  typedef struct packed {
    logic [6:0] funct7;
    logic [4:0] src2Sel;
    logic [4:0] src1Sel;
    logic [2:0] funct3;
    logic [4:0] destSel;
    logic [6:0] opcode;
  } instr_t;

endpackage

//--- rtl/crypto_bitperm_alu.sv
// Single-cycle execution unit for key round step, interleaves, XNOR and table lookups
`timescale 1ns/1ps

// Notes on behaviour
// - Key step: select byte, substitute, mix, XOR
// - Key step result sign-extended from 32 bits
// - Fixed latency, independent of operand values
// - De-interleave: even bits low, odd high
// - Interleave: low half even, high half odd
// - Interleaves legal only at 32-bit width
// - XNOR is complement of XOR, full width
// - Byte lookup: table from first operand
// - Byte entry: shift by index*8, keep byte
// - Nibble lookup: shift by index*4, keep nibble
// - Out-of-range index yields zero lane
module crypto_bitperm_alu #(
  parameter int XLEN = 32  // Register width, 32 or 64
) (
  input  wire logic                        ref_clk,
  input  wire logic                        reset,
  input  wire logic                        issueValid,
  input  wire crypto_bitperm_pkg::instr_t  instr,
  input  wire logic [XLEN-1:0]             srcA,
  input  wire logic [XLEN-1:0]             srcB,
  output logic                             doneValid,
  output logic                             illegalInstr,
  output logic [XLEN-1:0]                  result
);

  localparam int N8 = XLEN / 8;  // Byte table entries
  localparam int N4 = XLEN / 4;  // Nibble table entries

  // All state of the unit; nothing survives past one instruction
  typedef struct packed {
    logic            valid;
    logic            illegal;
    logic [XLEN-1:0] data;
  } state_t;

  state_t state_r;    // Registered answer
  state_t state_nxt;  // Next answer

  // Decoded operation strobes
  logic opKey;
  logic opZip;
  logic opUnzip;
  logic opXnor;
  logic opLut8;
  logic opLut4;
  logic anyOp;

  logic [1:0]      byteSel;    // Byte selector of key step
  logic [7:0]      keyByte;    // Selected source byte
  logic [7:0]      sboxOut;    // Substituted byte
  logic [31:0]     mixWord;    // Substituted byte at bit 0
  logic [31:0]     linOut;     // Linear layer output
  logic [31:0]     keyWord;    // Rotated and XORed word
  logic [XLEN-1:0] keyRes;     // Sign-extended key result
  logic [XLEN-1:0] zipRes;     // Interleave result
  logic [XLEN-1:0] unzipRes;   // De-interleave result
  logic [XLEN-1:0] lut8Res;    // Byte lookup result
  logic [XLEN-1:0] lut4Res;    // Nibble lookup result

  // Rotate left within 32 bits; a zero count gives v back
  function automatic logic [31:0] rol32(input logic [31:0] v, input logic [4:0] n);
    rol32 = (v << n) | (v >> (6'd32 - {1'b0, n}));
  endfunction

  // Decoding on opcode, funct3 and funct7 or the immediate; width gates the interleaves
  assign opKey   = instr.opcode == crypto_bitperm_pkg::OPC_REG
                && instr.funct3 == crypto_bitperm_pkg::F3_KEYSTEP
                && instr.funct7[4:0] == crypto_bitperm_pkg::F7_KEYSTEP_LOW;
  assign opZip   = XLEN == 32 && instr.opcode == crypto_bitperm_pkg::OPC_IMM
                && instr.funct3 == crypto_bitperm_pkg::F3_ZIP
                && {instr.funct7, instr.src2Sel} == crypto_bitperm_pkg::IMM_ZIP;
  assign opUnzip = XLEN == 32 && instr.opcode == crypto_bitperm_pkg::OPC_IMM
                && instr.funct3 == crypto_bitperm_pkg::F3_UNZIP
                && {instr.funct7, instr.src2Sel} == crypto_bitperm_pkg::IMM_ZIP;
  assign opXnor  = instr.opcode == crypto_bitperm_pkg::OPC_REG
                && instr.funct3 == crypto_bitperm_pkg::F3_XNOR
                && instr.funct7 == crypto_bitperm_pkg::F7_XNOR;
  assign opLut8  = instr.opcode == crypto_bitperm_pkg::OPC_REG
                && instr.funct3 == crypto_bitperm_pkg::F3_LUT8
                && instr.funct7 == crypto_bitperm_pkg::F7_LUT;
  assign opLut4  = instr.opcode == crypto_bitperm_pkg::OPC_REG
                && instr.funct3 == crypto_bitperm_pkg::F3_LUT4
                && instr.funct7 == crypto_bitperm_pkg::F7_LUT;
  assign anyOp   = opKey | opZip | opUnzip | opXnor | opLut8 | opLut4;

  // Key step datapath; the table is a flat mux, no data-dependent timing
  assign byteSel = instr.funct7[6:5];
  assign keyByte = 8'(srcB[31:0] >> {byteSel, 3'b000});
  assign sboxOut = crypto_bitperm_pkg::SBOX[{~keyByte, 3'b000} +: 8];
  assign mixWord = {24'h000000, sboxOut};
  assign linOut  = mixWord ^ rol32(mixWord, crypto_bitperm_pkg::ROT_A)
                 ^ rol32(mixWord, crypto_bitperm_pkg::ROT_B);
  assign keyWord = rol32(linOut, {byteSel, 3'b000}) ^ srcA[31:0];
  assign keyRes  = XLEN'($signed(keyWord));

  // Bit interleave and de-interleave
  for (genvar i = 0; i < XLEN / 2; i++)
  begin : g_zip
    assign unzipRes[i]          = srcA[2*i];
    assign unzipRes[i+XLEN/2]   = srcA[2*i+1];
    assign zipRes[2*i]          = srcA[i];
    assign zipRes[2*i+1]        = srcA[i+XLEN/2];
  end

  // Byte lookup lanes
  for (genvar l = 0; l < N8; l++)
  begin : g_lut8
    logic [7:0] idx8;  // Lane index
    assign idx8 = srcB[8*l +: 8];
    assign lut8Res[8*l +: 8] = (int'(idx8) < N8)
                             ? 8'(srcA >> {idx8, 3'b000}) : 8'h00;
  end

  // Nibble lookup lanes
  for (genvar l = 0; l < N4; l++)
  begin : g_lut4
    logic [3:0] idx4;  // Lane index
    assign idx4 = srcB[4*l +: 4];
    assign lut4Res[4*l +: 4] = (int'(idx4) < N4)
                             ? 4'(srcA >> {idx4, 2'b00}) : 4'h0;
  end

  // Next answer; every op completes the cycle after issue
  always_comb
  begin
    state_nxt = '0;
    if (issueValid)
    begin
      state_nxt.valid = 1'b1;
      if (opKey)
        state_nxt.data = keyRes;
      else if (opZip)
        state_nxt.data = zipRes;
      else if (opUnzip)
        state_nxt.data = unzipRes;
      else if (opXnor)
        state_nxt.data = ~(srcA ^ srcB);
      else if (opLut8)
        state_nxt.data = lut8Res;
      else if (opLut4)
        state_nxt.data = lut4Res;
      else
        state_nxt.illegal = 1'b1;  // Unknown word: flag, result zero
    end
  end

  // Answer register
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign doneValid    = state_r.valid;
  assign illegalInstr = state_r.illegal;
  assign result       = state_r.data;

  // Checks on the answer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Timing: one answer per issue, exactly one cycle later
  a_fixed_latency: assert property (
    issueValid |=> doneValid ##1 (!doneValid || $past(issueValid)))
    else $error("Answer not one cycle after issue");
  a_no_spurious: assert property (
    !issueValid |=> !doneValid)
    else $error("Answer without issue");

  // Key step: sign extension and the final XOR with the first operand
  a_key_signext: assert property (
    issueValid && opKey |=> !illegalInstr && result == XLEN'($signed(result[31:0])))
    else $error("Key step result not sign-extended");
  a_key_xor: assert property (
    issueValid && opKey |=> (result[31:0] ^ $past(srcA[31:0]))
                            == rol32($past(linOut), {$past(byteSel), 3'b000}))
    else $error("Key step not XORed with first operand");

  // Interleaves: corner bits of each half, and refusal on a wide base
  a_unzip_bits: assert property (
    issueValid && opUnzip |=> result[0] == $past(srcA[0])
                              && result[XLEN/2] == $past(srcA[1]))
    else $error("De-interleave bit placement wrong");
  a_zip_bits: assert property (
    issueValid && opZip |=> result[1] == $past(srcA[XLEN/2])
                            && result[XLEN-2] == $past(srcA[XLEN/2-1]))
    else $error("Interleave bit placement wrong");
  // Only reachable when the unit is built wide; every immediate-group word is refused then
  a_zip_width: assert property (
    XLEN != 32 && issueValid && instr.opcode == crypto_bitperm_pkg::OPC_IMM |=> illegalInstr)
    else $error("Interleave accepted on wide base");

  // XNOR over the full width
  a_xnor_value: assert property (
    issueValid && opXnor |=> result == ~($past(srcA) ^ $past(srcB)))
    else $error("XNOR result wrong");

  // Lookups: a fixed pick in lane zero and the out-of-range zero; then the unknown-word refusal with zero result
  a_lut8_pick: assert property (
    issueValid && opLut8 && srcB[7:0] == 8'h01 |=> result[7:0] == $past(srcA[15:8]))
    else $error("Byte lookup picked wrong entry");
  a_lut8_range: assert property (
    issueValid && opLut8 && int'(srcB[7:0]) >= N8 |=> result[7:0] == 8'h00)
    else $error("Byte lookup out of range not zero");
  a_lut4_pick: assert property (
    issueValid && opLut4 && srcB[3:0] == 4'h2 |=> result[3:0] == $past(srcA[11:8]))
    else $error("Nibble lookup picked wrong entry");
  a_illegal_zero: assert property (
    issueValid && !anyOp |=> illegalInstr && result == '0)
    else $error("Unknown word not flagged");

  // Scenarios worth seeing at least once
  c_key_step: cover property (issueValid && opKey && byteSel == 2'h3);
  c_lut_range: cover property (issueValid && opLut4 && srcB[3:0] == 4'hf);
  c_illegal: cover property (issueValid && !anyOp ##1 issueValid && opXnor);
  c_interleave: cover property (issueValid && opZip ##1 issueValid && opUnzip);

endmodule

//--- tb/pipe_issuer.sv
// Pipeline-side issuer presenting instruction words and operands
`timescale 1ns/1ps
module pipe_issuer #(
  parameter int XLEN = 32  // Register width
) (
  output logic                       issueValid,
  output crypto_bitperm_pkg::instr_t instr,
  output logic [XLEN-1:0]            srcA,
  output logic [XLEN-1:0]            srcB
);
  // Quiet from time zero
  initial
  begin
    issueValid = 1'b0;
    instr      = '0;
    srcA       = '0;
    srcB       = '0;
  end
  // One word per call, caller stands on a falling edge
  task automatic issue(input logic [31:0] w, input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
    issueValid = 1'b1;
    instr      = w;
    srcA       = a;
    srcB       = b;
  endtask
  // Released lines flip, so a stale word never looks like a fresh one
  task automatic idle();
    issueValid = 1'b0;
    instr      = ~instr;
    srcA       = ~srcA;
    srcB       = ~srcB;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the crypto and bit-permutation unit
`timescale 1ns/1ps
module tb;
  localparam int              XLEN = 32;       // Width under test
  logic                       ref_clk = 1'b0;  // Core clock
  logic                       reset   = 1'b1;  // Synchronous reset
  logic                       issueValid;      // Issue strobe
  crypto_bitperm_pkg::instr_t instr;           // Instruction word
  logic [XLEN-1:0]            srcA;            // Table or first operand
  logic [XLEN-1:0]            srcB;            // Indexes or second operand
  logic                       doneValid;       // Answer strobe
  logic                       illegalInstr;    // Refusal flag
  logic [XLEN-1:0]            result;          // Answer word
  int                         err_total = 0;   // Mismatches
  int                         tests_run = 0;   // Comparisons
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  pipe_issuer #(.XLEN(XLEN)) pipe_issuer_i (.issueValid(issueValid), .instr(instr),
    .srcA(srcA), .srcB(srcB));
  crypto_bitperm_alu #(.XLEN(XLEN)) crypto_bitperm_alu_i (.ref_clk(ref_clk), .reset(reset),
    .issueValid(issueValid), .instr(instr), .srcA(srcA), .srcB(srcB), .doneValid(doneValid),
    .illegalInstr(illegalInstr), .result(result));
  // Compare a word, case equality so unknowns fail
  task automatic cmp_word(input string what, input logic [XLEN-1:0] e, input logic [XLEN-1:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  // Compare a flag
  task automatic cmp_bit(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, e, g);
    end
  endtask
  // Register-register word, operand fields arbitrary
  function automatic logic [31:0] w_reg(input logic [6:0] f7, input logic [2:0] f3);
    return {f7, 5'h02, 5'h01, f3, 5'h03, crypto_bitperm_pkg::OPC_REG};
  endfunction
  // Key step reference: pick byte, substitute, mix, rotate, XOR
  function automatic logic [31:0] key_ref(input logic [1:0] s, input logic [31:0] a, b);
    logic [7:0]  k;
    logic [31:0] x;
    logic [31:0] y;
    k = b[8*s +: 8];
    x = {24'h0, crypto_bitperm_pkg::SBOX[2047-8*k -: 8]};
    y = x ^ {x[18:0], x[31:19]} ^ {x[8:0], x[31:9]};
    return ((y << (8*s)) | (y >> (32-8*s))) ^ a;
  endfunction
  // Interleave reference, or its inverse
  function automatic logic [31:0] zip_ref(input logic [31:0] v, input logic inv);
    logic [31:0] r;
    for (int i = 0; i < 16; i++)
    begin
      if (inv)
        {r[i+16], r[i]} = {v[2*i+1], v[2*i]};
      else
        {r[2*i+1], r[2*i]} = {v[i+16], v[i]};
    end
    return r;
  endfunction
  // Lookup reference for lane width w; out-of-range index gives zero
  function automatic logic [XLEN-1:0] lut_ref(input int w, input logic [XLEN-1:0] a, b);
    logic [XLEN-1:0] r;
    logic [XLEN-1:0] m;
    logic [XLEN-1:0] ix;
    r = '0;
    m = (1 << w) - 1;
    for (int l = 0; l < XLEN; l += w)
    begin
      ix = (b >> l) & m;
      if (ix < XLEN / w)
        r |= ((a >> (ix * w)) & m) << l;
    end
    return r;
  endfunction
  // One issue, answer judged once the fixed latency has passed
  task automatic exec(input logic [31:0] w, input logic [XLEN-1:0] a, b, e, input logic ill);
    pipe_issuer_i.issue(w, a, b);
    repeat (crypto_bitperm_pkg::LATENCY_CYCLES) @(negedge ref_clk);
    cmp_bit("doneValid", 1'b1, doneValid);
    cmp_bit("illegalInstr", ill, illegalInstr);
    cmp_word("result", e, result);
  endtask
  // Release the issuer; answer must clear after one cycle
  task automatic quiet(input string name);
    pipe_issuer_i.idle();
    @(negedge ref_clk);
    cmp_bit("doneValid idle", 1'b0, doneValid);
    cmp_word("result idle", '0, result);
    $display("test %s done", name);
  endtask
  // Key step at all four byte selectors, back to back
  task automatic t_key();
    logic [31:0] a;
    logic [31:0] b;
    a = 32'h0123abcd;
    b = 32'hc3a55a3c;
    for (int s = 0; s < 4; s++)
      exec(w_reg({s[1:0], crypto_bitperm_pkg::F7_KEYSTEP_LOW}, 3'h0), a, b,
        key_ref(s[1:0], a, b), 1'b0);
    quiet("key step");
  endtask
  // Interleave then de-interleave, back to back
  task automatic t_interleave();
    exec({12'h08f, 5'h01, 3'h1, 5'h03, 7'h13}, 32'hf0f01234, '0,
      zip_ref(32'hf0f01234, 1'b0), 1'b0);
    exec({12'h08f, 5'h01, 3'h5, 5'h03, 7'h13}, 32'h9a3c5f01, '0,
      zip_ref(32'h9a3c5f01, 1'b1), 1'b0);
    quiet("interleave");
  endtask
  // XNOR across the full width
  task automatic t_xnor();
    exec(w_reg(7'h20, 3'h4), 32'h5a5a00ff, 32'h0f0f0f0f, 32'haaaaf00f, 1'b0);
    quiet("xnor");
  endtask
  // Both lookups: in-range picks, out-of-range lanes in lane zero as well
  task automatic t_lookup();
    exec(w_reg(7'h14, 3'h4), 32'h44332211, 32'h7f040301, 32'h00004422, 1'b0);
    exec(w_reg(7'h14, 3'h4), 32'h44332211, 32'h02ff0180, 32'h33002200, 1'b0);
    exec(w_reg(7'h14, 3'h2), 32'hfedcba98, 32'hf0000ab2, 32'h0888800a, 1'b0);
    exec(w_reg(7'h14, 3'h2), 32'hfedcba98, 32'h9f107e2f,
      lut_ref(4, 32'hfedcba98, 32'h9f107e2f), 1'b0);
    quiet("lookup");
  endtask
  // Refused words, then a legal word straight after
  task automatic t_illegal();
    logic [31:0] bad [3];
    bad = '{w_reg(7'h21, 3'h4), {25'h0, 7'h37}, {12'h08e, 5'h01, 3'h1, 5'h03, 7'h13}};
    foreach (bad[i])
      exec(bad[i], 32'hffffffff, 32'h12345678, '0, 1'b1);
    exec(w_reg(7'h20, 3'h4), 32'h0, 32'h0, 32'hffffffff, 1'b0);
    quiet("illegal");
  endtask
  // Reset landing on an issue drops it; the first issue after release is answered
  task automatic t_reset();
    pipe_issuer_i.issue(w_reg(7'h20, 3'h4), 32'h0, 32'h0);
    reset = 1'b1;
    @(negedge ref_clk);
    cmp_bit("doneValid in reset", 1'b0, doneValid);
    cmp_word("result in reset", '0, result);
    reset = 1'b0;
    exec(w_reg(7'h20, 3'h4), 32'h0f0f0f0f, 32'h0f0f0f0f, 32'hffffffff, 1'b0);
    quiet("reset");
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset, then the scenario
  initial
  begin
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    @(negedge ref_clk);
    cmp_bit("doneValid reset", 1'b0, doneValid);
    cmp_word("result reset", '0, result);
    t_key();
    t_interleave();
    t_xnor();
    t_lookup();
    t_illegal();
    t_reset();
    wrap_up();
  end
  // Watchdog, far beyond the few dozen cycles needed
  initial
  begin
    #50000;
    err_total++;
    wrap_up();
  end
endmodule
